// ### hdl/hco_top.v
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "hco_map.vh"
module hco_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire frame_start,
    input wire line_start,
    input wire [10:0] line_next_y,
    input wire pix_valid,
    input wire [10:0] pix_x,
    input wire [10:0] pix_y,
    input wire [23:0] pix_in,
    output reg pix_out_valid,
    output reg [23:0] pix_out,
    output wire mem_req,
    output wire [21:0] mem_addr,
    input wire mem_ack,
    input wire [31:0] mem_rdata
);

    // Software-visible state
    reg [7:0] lock_r;
    reg mode_en_r;
    reg [2:0] x_hi_r;
    reg [7:0] x_lo_r;
    reg [2:0] y_hi_r;
    reg [7:0] y_lo_r;
    reg [23:0] fg_r;
    reg [23:0] bg_r;
    reg [1:0] fg_ptr_r;
    reg [1:0] bg_ptr_r;
    reg [3:0] s_hi_r;
    reg [7:0] s_lo_r;
    reg [5:0] x_ofs_r;
    reg [5:0] y_ofs_r;
    reg style_r;
    reg enh_r;
    reg [10:0] hact_r;
    reg [10:0] vact_r;

    // Per-frame copies of the placement
    reg [10:0] act_x_r;
    reg [10:0] act_y_r;
    reg [5:0] act_xo_r;
    reg [5:0] act_yo_r;
    reg [11:0] act_seg_r;

    // Bus pipeline state
    reg wr_pend_r;
    reg [6:0] wr_addr_r;
    reg rd_pend_r;
    reg [6:0] rd_addr_r;

    wire unlocked;
    wire addr_phase;
    wire cursor_on;
    wire fetch_busy;
    wire [63:0] and_row;
    wire [63:0] xor_row;
    wire [23:0] resolved;
    wire [6:0] next_img;
    wire [6:0] pix_img;
    reg [31:0] rd_mux;
    reg [5:0] fetch_row;
    reg fetch_go;
    reg in_win;
    reg [5:0] col;
    reg and_b;
    reg xor_b;

    // Stack byte lookup, used for both color stacks
    function [7:0] stack_byte;
        input [23:0] stk;
        input [1:0] ptr;
        begin
            case (ptr)
                2'h0: stack_byte = stk[7:0];
                2'h1: stack_byte = stk[15:8];
                default: stack_byte = stk[23:16];
            endcase
        end
    endfunction

    // Image row for a screen line, or out of range flag in bit 6
    function [6:0] image_row;
        input [10:0] y;
        input [10:0] ypos;
        input [5:0] yofs;
        input [10:0] vact;
        reg [11:0] d;
        begin
            d = {1'b0, y} - {1'b0, ypos} + {6'h00, yofs};
            if (y < ypos || y >= vact || ypos >= vact || d >= 12'h040)
                image_row = 7'h40;
            else
                image_row = {1'b0, d[5:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: writes complete in their data phase, reads take one wait
    assign addr_phase = hsel && htrans[1] && hready;
    assign unlocked = (lock_r == `HCO_UNLOCK_KEY);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 7'h00;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 7'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend_r <= addr_phase && hwrite;
            // Word-aligned offsets only; upper address bits are not decoded
            if (addr_phase)
            begin
                wr_addr_r <= {haddr[6:2], 2'b00};
                rd_addr_r <= {haddr[6:2], 2'b00};
            end
            if (addr_phase && !hwrite)
            begin
                // Hold one cycle so a preceding write lands first
                rd_pend_r <= 1'b1;
                hreadyout <= 1'b0;
            end
            else if (rd_pend_r)
            begin
                rd_pend_r <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= rd_mux;
            end
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (rd_addr_r)
            {`HCO_OFS_LOCK}: rd_mux[7:0] = lock_r;
            {`HCO_OFS_MODE}: rd_mux[`HCO_MODE_EN_BIT] = mode_en_r;
            {`HCO_OFS_XHI}: rd_mux[2:0] = x_hi_r;
            {`HCO_OFS_XLO}: rd_mux[7:0] = x_lo_r;
            {`HCO_OFS_YHI}: rd_mux[2:0] = y_hi_r;
            {`HCO_OFS_YLO}: rd_mux[7:0] = y_lo_r;
            {`HCO_OFS_FG}: rd_mux[7:0] = stack_byte(fg_r, fg_ptr_r);
            {`HCO_OFS_BG}: rd_mux[7:0] = stack_byte(bg_r, bg_ptr_r);
            {`HCO_OFS_SHI}: rd_mux[3:0] = s_hi_r;
            {`HCO_OFS_SLO}: rd_mux[7:0] = s_lo_r;
            {`HCO_OFS_XOFS}: rd_mux[5:0] = x_ofs_r;
            {`HCO_OFS_YOFS}: rd_mux[5:0] = y_ofs_r;
            {`HCO_OFS_STYLE}: rd_mux[`HCO_STYLE_BIT] = style_r;
            {`HCO_OFS_ENH}: rd_mux[`HCO_ENH_BIT] = enh_r;
            {`HCO_OFS_HACT}: rd_mux[10:0] = hact_r;
            {`HCO_OFS_VACT}: rd_mux[10:0] = vact_r;
            {`HCO_OFS_STAT}: rd_mux[5:0] = {fg_ptr_r, bg_ptr_r,
                fetch_busy, cursor_on};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; lock gates all cursor registers but itself and enhanced mode
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_r <= `HCO_RELOCK_KEY;
            mode_en_r <= 1'b0;
            x_hi_r <= 3'h0;
            x_lo_r <= 8'h00;
            y_hi_r <= 3'h0;
            y_lo_r <= 8'h00;
            fg_r <= 24'h00_0000;
            bg_r <= 24'h00_0000;
            fg_ptr_r <= 2'h0;
            bg_ptr_r <= 2'h0;
            s_hi_r <= 4'h0;
            s_lo_r <= 8'h00;
            x_ofs_r <= 6'h00;
            y_ofs_r <= 6'h00;
            style_r <= 1'b0;
            enh_r <= 1'b0;
            hact_r <= `HCO_RST_HACT;
            vact_r <= `HCO_RST_VACT;
        end
        else
        begin
            // Mode register read rewinds both color stacks
            if (rd_pend_r && rd_addr_r == `HCO_OFS_MODE)
            begin
                fg_ptr_r <= 2'h0;
                bg_ptr_r <= 2'h0;
            end
            if (wr_pend_r && wr_addr_r == `HCO_OFS_LOCK)
                lock_r <= hwdata[7:0];
            else if (wr_pend_r && wr_addr_r == `HCO_OFS_ENH)
                enh_r <= hwdata[`HCO_ENH_BIT];
            else if (wr_pend_r && unlocked)
            begin
                case (wr_addr_r)
                    `HCO_OFS_MODE: mode_en_r <= hwdata[`HCO_MODE_EN_BIT];
                    `HCO_OFS_XHI: x_hi_r <= hwdata[2:0];
                    `HCO_OFS_XLO: x_lo_r <= hwdata[7:0];
                    `HCO_OFS_YHI: y_hi_r <= hwdata[2:0];
                    `HCO_OFS_YLO: y_lo_r <= hwdata[7:0];
                    `HCO_OFS_FG:
                    begin
                        // Low byte first, pointer steps per write
                        case (fg_ptr_r)
                            2'h0: fg_r[7:0] <= hwdata[7:0];
                            2'h1: fg_r[15:8] <= hwdata[7:0];
                            default: fg_r[23:16] <= hwdata[7:0];
                        endcase
                        fg_ptr_r <= (fg_ptr_r == 2'h2) ? 2'h0 :
                            fg_ptr_r + 2'h1;
                    end
                    `HCO_OFS_BG:
                    begin
                        case (bg_ptr_r)
                            2'h0: bg_r[7:0] <= hwdata[7:0];
                            2'h1: bg_r[15:8] <= hwdata[7:0];
                            default: bg_r[23:16] <= hwdata[7:0];
                        endcase
                        bg_ptr_r <= (bg_ptr_r == 2'h2) ? 2'h0 :
                            bg_ptr_r + 2'h1;
                    end
                    `HCO_OFS_SHI: s_hi_r <= hwdata[3:0];
                    `HCO_OFS_SLO: s_lo_r <= hwdata[7:0];
                    `HCO_OFS_XOFS: x_ofs_r <= hwdata[5:0];
                    `HCO_OFS_YOFS: y_ofs_r <= hwdata[5:0];
                    `HCO_OFS_STYLE: style_r <= hwdata[`HCO_STYLE_BIT];
                    `HCO_OFS_HACT: hact_r <= hwdata[10:0];
                    `HCO_OFS_VACT: vact_r <= hwdata[10:0];
                    default: lock_r <= lock_r;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Placement is sampled at frame start, so mid-frame writes never tear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_x_r <= 11'h000;
            act_y_r <= 11'h000;
            act_xo_r <= 6'h00;
            act_yo_r <= 6'h00;
            act_seg_r <= 12'h000;
        end
        else if (frame_start)
        begin
            act_x_r <= {x_hi_r, x_lo_r};
            act_y_r <= {y_hi_r, y_lo_r};
            act_xo_r <= x_ofs_r;
            act_yo_r <= y_ofs_r;
            act_seg_r <= {s_hi_r, s_lo_r};
        end
    end

    // Cursor only in enhanced mode and when enabled
    assign cursor_on = enh_r && mode_en_r;

    ////////////////////////////////////////////////////////////////////////
    // Image row for the coming line and for the current pixel
    assign next_img = image_row(line_next_y, act_y_r, act_yo_r, vact_r);
    assign pix_img = image_row(pix_y, act_y_r, act_yo_r, vact_r);

    // Row fetch during blanking for the line about to be drawn
    always @*
    begin
        fetch_row = next_img[5:0];
        fetch_go = line_start && cursor_on && !next_img[6];
    end

    hco_fetch u_fetch (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(fetch_go),
        .seg(act_seg_r),
        .row(fetch_row),
        .mem_req(mem_req),
        .mem_addr(mem_addr),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata),
        .busy(fetch_busy),
        .and_row(and_row),
        .xor_row(xor_row)
    );

    ////////////////////////////////////////////////////////////////////////
    // Window test and mask bit pick for the incoming pixel
    always @*
    begin : win_blk
        reg [11:0] dx;
        dx = {1'b0, pix_x} - {1'b0, act_x_r} + {6'h00, act_xo_r};
        col = dx[5:0];
        in_win = cursor_on && pix_x >= act_x_r && pix_x < hact_r &&
            dx < 12'h040 &&
            !pix_img[6];
        and_b = and_row[6'h3f - col];
        xor_b = xor_row[6'h3f - col];
    end

    hco_resolve u_resolve (
        .style(style_r),
        .and_bit(and_b),
        .xor_bit(xor_b),
        .scr(pix_in),
        .fg(fg_r),
        .bg(bg_r),
        .pix(resolved)
    );

    // Output stage: one cycle latency for every pixel
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_out_valid <= 1'b0;
            pix_out <= 24'h00_0000;
        end
        else
        begin
            pix_out_valid <= pix_valid;
            pix_out <= in_win ? resolved : pix_in;
        end
    end

endmodule // hco_top

// ### pkg/hco_map.vh
// Summary of operation
// - Style bit 4 picks desktop (0) or workstation (1) mask convention.
// - Cursor is 64x64, shaped by 512-byte AND and XOR mask images.
// - Desktop: 00 bg, 01 fg, 10 screen, 11 inverted screen.
// - Workstation: AND 0 shows screen; AND 1 gives bg or fg by XOR.
// - Foreground and background colors are stacks of three bytes each.
// - Mode register read zeroes both stack pointers; writes go low byte first.
// - Cursor off outside enhanced mode; mode bit 0 turns it on or off.
// - Cursor registers except lock and enhanced mode writable only after A0H in lock register; 00H relocks.
// - X and Y are 11-bit, split as 3 high and 8 low bits.
// - Clip at right and bottom edges; Y past last line hides cursor.
// - Y offset 0..63 skips that many top rows of the image.
// - X offset 0..63 skips that many left columns of the image.
// - New position taken once per frame; software updates once per vsync.
// - Masks fetched word-interleaved: AND word, XOR word, up to word 255.
// - Image start is a 12-bit index of 1024-byte segments.
`ifndef HCO_MAP_VH
`define HCO_MAP_VH

// Register byte offsets on the bus
`define HCO_OFS_LOCK 7'h00
`define HCO_OFS_MODE 7'h04
`define HCO_OFS_XHI 7'h08
`define HCO_OFS_XLO 7'h0c
`define HCO_OFS_YHI 7'h10
`define HCO_OFS_YLO 7'h14
`define HCO_OFS_FG 7'h18
`define HCO_OFS_BG 7'h1c
`define HCO_OFS_SHI 7'h20
`define HCO_OFS_SLO 7'h24
`define HCO_OFS_XOFS 7'h28
`define HCO_OFS_YOFS 7'h2c
`define HCO_OFS_STYLE 7'h30
`define HCO_OFS_ENH 7'h34
`define HCO_OFS_HACT 7'h38
`define HCO_OFS_VACT 7'h3c
`define HCO_OFS_STAT 7'h40

// Field positions and key values
`define HCO_MODE_EN_BIT 0
`define HCO_STYLE_BIT 4
`define HCO_ENH_BIT 0
`define HCO_UNLOCK_KEY 8'ha0
`define HCO_RELOCK_KEY 8'h00
`define HCO_CUR_SIZE 7'h40
`define HCO_SEG_SHIFT 10
`define HCO_ROW_BYTES 5'h10
`define HCO_WORDS_PER_ROW 3'h4

// Reset values
`define HCO_RST_HACT 11'h400
`define HCO_RST_VACT 11'h300

`endif

// ### hdl/hco_resolve.v
`timescale 1ns/1ps
module hco_resolve (
    input wire style,
    input wire and_bit,
    input wire xor_bit,
    input wire [23:0] scr,
    input wire [23:0] fg,
    input wire [23:0] bg,
    output reg [23:0] pix
);

    // Truth table for both conventions
    always @*
    begin
        if (!style)
        begin
            case ({and_bit, xor_bit})
                2'b00: pix = bg;
                2'b01: pix = fg;
                2'b10: pix = scr;
                default: pix = ~scr;
            endcase
        end
        else if (!and_bit)
            pix = scr;
        else
            pix = xor_bit ? fg : bg;
    end

endmodule // hco_resolve

// ### hdl/hco_fetch.v
`timescale 1ns/1ps
`include "hco_map.vh"
module hco_fetch (
    input wire hclk,
    input wire hresetn,
    input wire start,
    input wire [11:0] seg,
    input wire [5:0] row,
    output reg mem_req,
    output reg [21:0] mem_addr,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    output reg busy,
    output reg [63:0] and_row,
    output reg [63:0] xor_row
);

    reg [1:0] word_r;
    wire [21:0] row_base;

    // Segment index to byte address, plus row stride
    assign row_base = {seg, 10'h000} + {12'h000, row, 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Four reads per row; each word holds an AND word and its XOR twin
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mem_req <= 1'b0;
            mem_addr <= 22'h00_0000;
            busy <= 1'b0;
            word_r <= 2'h0;
            and_row <= 64'hffff_ffff_ffff_ffff;
            xor_row <= 64'h0000_0000_0000_0000;
        end
        else if (start && !busy)
        begin
            busy <= 1'b1;
            mem_req <= 1'b1;
            word_r <= 2'h0;
            mem_addr <= row_base;
        end
        else if (busy && mem_ack)
        begin
            // Low half is the AND word, high half the XOR word
            and_row <= {and_row[47:0], mem_rdata[15:0]};
            xor_row <= {xor_row[47:0], mem_rdata[31:16]};
            if (word_r == 2'h3)
            begin
                busy <= 1'b0;
                mem_req <= 1'b0;
            end
            else
            begin
                word_r <= word_r + 2'h1;
                mem_addr <= mem_addr + 22'h00_0004;
            end
        end
    end

endmodule // hco_fetch

// ### verif/hco_top_assertions.sv
`timescale 1ns/1ps
module hco_top_assertions (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire pix_valid,
    input wire pix_out_valid,
    input wire mem_req,
    input wire [21:0] mem_addr,
    input wire mem_ack
);
    wire rd_take = hsel & htrans[1] & hready & ~hwrite;
    wire wr_take = hsel & htrans[1] & hready & hwrite;
    reg [2:0] acks_r;

    // Acks in one row fetch; cleared while the request is down
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            acks_r <= 3'h0;
        else if (!mem_req)
            acks_r <= 3'h0;
        else if (mem_ack)
            acks_r <= acks_r + 3'h1;
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////
    // Bus answer timing
    property p_rd_wait;
        rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("Read wait wrong");
    property p_wr_zero;
        wr_take |=> hreadyout;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("Write stalled");
    // Read data must not drift between reads
    property p_rd_hold;
        hreadyout && !rd_take |=> $stable(hrdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read data moved");
    // Pixel pipe is exactly one stage
    property p_pix_pipe;
        pix_out_valid == $past(pix_valid);
    endproperty
    a_pix_pipe: assert property (p_pix_pipe) else $error("Pixel lag");
    // Row fetch starts on a row boundary of 16 bytes
    property p_row_align;
        $rose(mem_req) |-> mem_addr[3:0] == 4'h0;
    endproperty
    a_row_align: assert property (p_row_align) else $error("Row addr");
    property p_addr_step;
        mem_req && mem_ack && acks_r != 3'h3 |=>
            mem_req && mem_addr == $past(mem_addr) + 22'h4;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("Step");
    // Request and address held while memory stalls
    property p_hold_req;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_hold_req: assert property (p_hold_req) else $error("Req drop");
    property p_four_words;
        mem_req && mem_ack && acks_r == 3'h3 |=> !mem_req;
    endproperty
    a_four_words: assert property (p_four_words) else $error("Count");
endmodule // hco_top_assertions

bind hco_top hco_top_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .pix_valid(pix_valid), .pix_out_valid(pix_out_valid),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack)
);

// ### verif/hco_mem_model.sv
`timescale 1ns/1ps
module hco_mem_model (
    input wire hclk,
    input wire hresetn,
    input wire [3:0] lat,
    input wire mem_req,
    input wire [21:0] mem_addr,
    output reg mem_ack,
    output wire [31:0] mem_rdata
);
    // Mask pair per word: AND low half, XOR high half, all four codes
    // Code 10 columns double as padded, transparent shape area in desktop style; workstation style shows them as bg
    localparam [31:0] WORD = 32'h3333_5555;
    reg [3:0] wait_r;

    // Outside the ack cycle the data is inverted to expose stale use
    assign mem_rdata = mem_ack ? WORD : ~WORD;

    // One ack pulse per word after lat idle cycles
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mem_ack <= 1'b0;
            wait_r <= 4'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack && wait_r >= lat)
            begin
                mem_ack <= 1'b1;
                wait_r <= 4'h0;
            end
            else if (mem_req && !mem_ack)
                wait_r <= wait_r + 4'h1;
        end
    end
endmodule // hco_mem_model

// ### verif/hardware_cursor_overlay_test.sv
`timescale 1ns/1ps
`include "hco_map.vh"
module hardware_cursor_overlay_test;
    localparam [23:0] FG = 24'h11_2233;
    localparam [23:0] BG = 24'h44_5566;
    reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    reg [1:0] htrans = 2'h0;
    reg frame_start = 1'b0, line_start = 1'b0, pix_valid = 1'b0;
    reg [10:0] line_next_y = 11'h000, pix_x = 11'h000, pix_y = 11'h000;
    reg [23:0] pix_in = 24'h00_0000;
    reg [3:0] lat = 4'h0;
    reg [10:0] xp;
    reg sty, on;
    wire hreadyout, hresp, pix_out_valid, mem_req, mem_ack;
    wire [31:0] hrdata, mem_rdata;
    wire [23:0] pix_out;
    wire [21:0] mem_addr;
    integer fails = 0, cmp_count = 0, xo, i, x;

    always #2.5 hclk = ~hclk;

    hco_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .frame_start(frame_start), .line_start(line_start),
        .line_next_y(line_next_y), .pix_valid(pix_valid), .pix_x(pix_x),
        .pix_y(pix_y), .pix_in(pix_in), .pix_out_valid(pix_out_valid),
        .pix_out(pix_out), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    hco_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .lat(lat),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    ////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task stop_test;
    begin
        $display("Compared %0d, mismatched %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // Bounded wait for a level on hreadyout (sel 1) or mem_req (sel 0)
    task till(input v, input sel);
        integer n;
    begin
        n = 0;
        while ((sel ? hreadyout : mem_req) !== v && n < 200)
        begin
            @(posedge hclk);
            n = n + 1;
        end
        if (n >= 200)
        begin
            fails = fails + 1;
            stop_test;
        end
    end
    endtask
    // Single word transfer; each phase held until ready seen high
    task bus(input w, input [6:0] a, input [31:0] d);
    begin
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {25'h000_0000, a};
        @(posedge hclk);
        till(1'b1, 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        till(1'b1, 1'b1);
        q = hrdata;
    end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        bus(1'b1, a, {24'h00_0000, d});
    endtask
    task rd(input [6:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task frame;
    begin
        @(posedge hclk);
        frame_start <= 1'b1;
        @(posedge hclk);
        frame_start <= 1'b0;
    end
    endtask
    // Placement in high/low parts, then one frame to take it
    task place(input [10:0] px, input [10:0] py, input [5:0] ox,
        input [5:0] oy);
    begin
        wr(`HCO_OFS_XHI, {5'h00, px[10:8]});
        wr(`HCO_OFS_XLO, px[7:0]);
        wr(`HCO_OFS_YHI, {5'h00, py[10:8]});
        wr(`HCO_OFS_YLO, py[7:0]);
        wr(`HCO_OFS_XOFS, {2'h0, ox});
        wr(`HCO_OFS_YOFS, {2'h0, oy});
        xp = px;
        xo = ox;
        frame;
    end
    endtask
    // Line start; a hit must fetch from the given byte address
    task row(input [10:0] y, input hit, input [21:0] a);
    begin
        @(posedge hclk);
        line_start <= 1'b1;
        line_next_y <= y;
        @(posedge hclk);
        line_start <= 1'b0;
        if (hit)
        begin
            till(1'b1, 1'b0);
            chk({10'h000, mem_addr}, {10'h000, a});
            till(1'b0, 1'b0);
        end
        else
        begin
            repeat (2) @(posedge hclk);
            chk({31'h0, mem_req}, 32'h0000_0000);
        end
    end
    endtask
    // Columns cycle 00,10,01,11 as AND/XOR codes from the model
    function [23:0] want(input [10:0] px, input [23:0] s);
        integer c;
    begin
        c = px - xp + xo;
        if (!on || px < xp || c > 63)
            want = s;
        else if (sty)
            want = c[0] ? (c[1] ? FG : BG) : s;
        else
            want = c[0] ? (c[1] ? ~s : s) : (c[1] ? FG : BG);
    end
    endfunction
    task px(input [10:0] x, input [10:0] y);
        reg [23:0] s;
    begin
        s = {x[7:0], 16'h5a3c};
        @(posedge hclk);
        pix_valid <= 1'b1;
        pix_x <= x;
        pix_y <= y;
        pix_in <= s;
        @(posedge hclk);
        pix_valid <= 1'b0;
        #1;
        chk({8'h00, pix_out}, {8'h00, want(x, s)});
    end
    endtask

    ////////////////////////////////////////
    task t_lock;
    begin
        chk({hreadyout, hresp, mem_req, pix_out_valid}, 32'h0000_0008);
        rd(`HCO_OFS_HACT);
        chk(q, 32'h0000_0400);
        rd(7'h3c);
        chk(q, 32'h0000_0300);
        rd(7'h44);
        chk(q, 32'h0000_0000);
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(`HCO_OFS_LOCK, i == 1 ? 8'ha0 : 8'h55);
            wr(`HCO_OFS_XLO, 8'h5a + i[7:0]);
            rd(`HCO_OFS_XLO);
            chk(q, i == 0 ? 32'h0 : 32'h5b);
        end
        wr(`HCO_OFS_LOCK, 8'h00);
        wr(`HCO_OFS_XLO, 8'h11);
        rd(`HCO_OFS_XLO);
        chk(q, 32'h0000_005b);
        wr(`HCO_OFS_LOCK, 8'ha0);
    end
    endtask
    // A stray byte first, so a missed pointer reset shows in the colour
    task t_color;
    begin
        wr(`HCO_OFS_FG, 8'hee);
        rd(`HCO_OFS_STAT);
        chk(q[5:2], 32'h4);
        rd(`HCO_OFS_MODE);
        rd(`HCO_OFS_STAT);
        chk(q[5:2], 32'h0);
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(`HCO_OFS_FG, FG[8 * i +: 8]);
            wr(`HCO_OFS_BG, BG[8 * i +: 8]);
        end
        rd(`HCO_OFS_FG);
        chk(q, 32'h0000_0033);
    end
    endtask
    task t_draw;
    begin
        wr(`HCO_OFS_ENH, 8'h01);
        wr(`HCO_OFS_MODE, 8'h01);
        wr(`HCO_OFS_SHI, 8'h03);
        wr(`HCO_OFS_SLO, 8'hfe);
        on = 1'b1;
        place(11'h105, 11'h00a, 6'h00, 6'h00);
        row(11'h00a, 1'b1, 22'h0f_f800);
        for (i = 0; i < 2; i = i + 1)
        begin
            sty = i[0];
            wr(`HCO_OFS_STYLE, {3'h0, sty, 4'h0});
            for (x = 259; x < 266; x = x + 1)
                px(x, 11'h00a);
        end
        wr(`HCO_OFS_XLO, 8'h20);
        px(11'h106, 11'h00a);
        on = 1'b0;
        px(11'h106, 11'h009);
    end
    endtask
    task t_skip;
    begin
        sty = 1'b0;
        lat <= 4'h3;
        wr(`HCO_OFS_STYLE, 8'h00);
        on = 1'b1;
        place(11'h105, 11'h00a, 6'h02, 6'h05);
        row(11'h00a, 1'b1, 22'h0f_f850);
        for (x = 259; x < 324; x = x + 1)
            if (x < 264 || x > 319)
                px(x, 11'h00a);
        row(11'h044, 1'b1, 22'h0f_fbf0);
        row(11'h045, 1'b0, 22'h0);
    end
    endtask
    task t_hide;
    begin
        on = 1'b0;
        place(11'h105, 11'h300, 6'h00, 6'h00);
        row(11'h2ff, 1'b0, 22'h0);
        place(11'h105, 11'h00a, 6'h00, 6'h00);
        wr(`HCO_OFS_ENH, 8'h00);
        frame;
        row(11'h00a, 1'b0, 22'h0);
        px(11'h106, 11'h00a);
        wr(`HCO_OFS_ENH, 8'h01);
        wr(`HCO_OFS_MODE, 8'h00);
        frame;
        row(11'h00a, 1'b0, 22'h0);
    end
    endtask

    initial
    begin
        sty = 1'b0;
        on = 1'b0;
        xp = 11'h000;
        xo = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_lock;
        t_color;
        t_draw;
        t_skip;
        t_hide;
        stop_test;
    end
endmodule // hardware_cursor_overlay_test
